// ### verilog/ddr2_mode_ctrl.sv
// controller end: apb slave holding orders; issues mode-register writes,
// self refresh entry/exit, enforces the command wait and flags in status when the dll lock wait has elapsed
// assumes the device end on the same clock
//
// Design decisions made here: the register offsets and register access over APB.
`timescale 1ns/100ps
module ddr2_mode_ctrl
   import ddr2_cfg_pkg::*;
#(
   parameter int MRD_WAIT = ddr2_cfg_pkg::MRD_CYCLES,
   parameter int LOCK_WAIT = ddr2_cfg_pkg::DLL_LOCK_CYCLES,
   parameter bit WIDE_PART = 1'b0
)
(
   // clock and reset
   input wire logic mclk_i,
   input wire logic sys_rst_i,
   input wire logic clk_en_i,
   // apb
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // system
   input wire logic all_precharged_i,
   // command pins
   ddr2_cmd_if.ctrl link
);
   import ddr2_cfg_pkg::*;

   // register offsets
   localparam logic [11:0] OFS_EXT = 12'h000;
   localparam logic [11:0] OFS_CTRL = 12'h004;
   localparam logic [11:0] OFS_STAT = 12'h008;
   localparam logic [11:0] OFS_BASE = 12'h00C;
   localparam logic [2:0] BANK_BASE = 3'h0; // bank code of the base mode register

   typedef enum logic [1:0] {ST_IDLE = 2'h0, ST_ISSUE = 2'h1, ST_WAIT = 2'h3}
      state_t;

   ////////////////////////////////////////////////////////////////////
   // apb registers

   logic [13:0] ext_q; // value to load
   logic go_q; // write request pending
   logic sr_req_q; // software wants self refresh
   logic [3:0] base_q; // burst fields to load into the base register
   logic tgt_base_q; // next load goes to the base register, not the extended one
   logic rd_ok_q; // dll lock wait elapsed
   logic done_q; // last write completed
   state_t state_q;
   logic [7:0] wait_q;
   logic wr_acc; // apb write access cycle

   assign wr_acc = psel_i && penable_i && pwrite_i;
   assign pready_o = 1'b1;
   assign pslverr_o = psel_i && penable_i && paddr_i != OFS_EXT && paddr_i != OFS_CTRL
      && paddr_i != OFS_STAT && paddr_i != OFS_BASE;

   // order register; bit 13 always written 0, read strobe cleared on wide part
   always_ff @(posedge mclk_i)
   begin
      if (sys_rst_i)
         ext_q <= EXT_ONE_RESET;
      else if (clk_en_i && wr_acc && paddr_i == OFS_EXT)
      begin
         ext_q <= {1'b0, pwdata_i[12:0]};
         if (WIDE_PART)
            ext_q[RSTROBE_ON_BIT] <= 1'b0;
      end
   end

   // burst fields for the base register, loaded by the same sequencer
   always_ff @(posedge mclk_i)
   begin
      if (sys_rst_i)
         base_q <= BASE_RESET;
      else if (clk_en_i && wr_acc && paddr_i == OFS_BASE)
         base_q <= pwdata_i[3:0];
   end

   // go and self refresh requests; a fresh control write wins over the clear at issue
   always_ff @(posedge mclk_i)
   begin
      if (sys_rst_i)
      begin
         go_q <= 1'b0;
         sr_req_q <= 1'b0;
         tgt_base_q <= 1'b0;
      end
      else if (clk_en_i)
      begin
         if (wr_acc && paddr_i == OFS_CTRL)
         begin
            go_q <= pwdata_i[0];
            sr_req_q <= pwdata_i[1];
            tgt_base_q <= pwdata_i[2];
         end
         else if (state_q == ST_ISSUE)
            go_q <= 1'b0;
      end
   end

   // read mux
   always_ff @(posedge mclk_i)
   begin
      if (sys_rst_i)
         prdata_o <= 32'h0000_0000;
      else if (clk_en_i && psel_i && !penable_i)
         case (paddr_i)
            OFS_EXT: prdata_o <= {18'h0, ext_q};
            OFS_CTRL: prdata_o <= {29'h0, tgt_base_q, sr_req_q, go_q};
            OFS_BASE: prdata_o <= {28'h0, base_q};
            OFS_STAT: prdata_o <= {28'h0, link.self_refresh, rd_ok_q, done_q,
               state_q != ST_IDLE};
            default: prdata_o <= 32'h0000_0000;
         endcase
   end

   ////////////////////////////////////////////////////////////////////
   // command sequencer

   // issue only with cke high and all banks precharged
   always_ff @(posedge mclk_i)
   begin
      if (sys_rst_i)
      begin
         state_q <= ST_IDLE;
         wait_q <= 8'h00;
         done_q <= 1'b0;
      end
      else if (clk_en_i)
      begin
         // a fresh go order forgets the previous completion; a finish in
         // the same cycle still sets done, since it is assigned later
         if (wr_acc && paddr_i == OFS_CTRL && pwdata_i[0])
            done_q <= 1'b0;
         case (state_q)
            ST_IDLE:
               if (go_q && link.cke && all_precharged_i && !sr_req_q)
               begin
                  state_q <= ST_ISSUE;
                  done_q <= 1'b0;
               end
            ST_ISSUE:
            begin
               state_q <= ST_WAIT;
               wait_q <= 8'(MRD_WAIT - 1);
            end
            ST_WAIT:
               if (wait_q == 8'h00)
               begin
                  state_q <= ST_IDLE;
                  done_q <= 1'b1;
               end
               else
                  wait_q <= wait_q - 8'h01;
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // dll lock counter restarts on each load that enables the dll
   logic [7:0] lock_q;
   always_ff @(posedge mclk_i)
   begin
      if (sys_rst_i)
      begin
         lock_q <= 8'h00;
         rd_ok_q <= 1'b0;
      end
      else if (clk_en_i)
      begin
         if ((state_q == ST_ISSUE && !tgt_base_q && !ext_q[DLL_OFF_BIT])
            || link.self_refresh)
         begin
            lock_q <= 8'(LOCK_WAIT - 1);
            rd_ok_q <= 1'b0;
         end
         else if (lock_q != 8'h00)
            lock_q <= lock_q - 8'h01;
         else
            rd_ok_q <= !ext_q[DLL_OFF_BIT];
      end
   end

   // pins: mode command during issue, cke low for self refresh
   // the refresh code must stand in the first cycle with cke low, so the
   // falling cycle is found from cke one cycle back; cke only drops when idle
   // so a self refresh never cuts into the command cycle time
   logic cke_q;
   logic cke_old_q; // cke one cycle back
   always_ff @(posedge mclk_i)
   begin
      if (sys_rst_i)
      begin
         cke_q <= 1'b0;
         cke_old_q <= 1'b0;
      end
      else if (clk_en_i)
      begin
         cke_q <= !(sr_req_q && all_precharged_i && state_q == ST_IDLE);
         cke_old_q <= cke_q;
      end
   end

   assign link.cke = cke_q;
   assign link.cs_n = !(state_q == ST_ISSUE || (cke_old_q && !cke_q));
   assign link.ras_n = link.cs_n;
   assign link.cas_n = link.cs_n;
   assign link.we_n = !(state_q == ST_ISSUE);
   assign link.ba = (state_q != ST_ISSUE) ? 3'h0 : tgt_base_q ? BANK_BASE : BANK_EXT_ONE;
   assign link.addr = (state_q != ST_ISSUE) ? 14'h0000 : tgt_base_q ? {10'h000, base_q}
      : ext_q;

endmodule // ddr2_mode_ctrl

// ### verilog/ddr2_cfg_pkg.sv
// package for the ddr2 burst ordering and extended mode one link
// assumes a single 25 MHz clock shared by controller and device ends
package ddr2_cfg_pkg;

   // address pin width and bank address width
   localparam int ADDR_W = 14;
   localparam int BANK_W = 3;

   // bank code that selects the first extended register
   localparam logic [2:0] BANK_EXT_ONE = 3'h1;

   // field positions inside extended_mode_one
   localparam int DLL_OFF_BIT = 0;
   localparam int DRIVE_HALF_BIT = 1;
   localparam int TERM_LO_BIT = 2;
   localparam int ALAT_LSB = 3;
   localparam int TERM_HI_BIT = 6;
   localparam int CAL_LSB = 7;
   localparam int NSTROBE_OFF_BIT = 10;
   localparam int RSTROBE_ON_BIT = 11;
   localparam int OUT_OFF_BIT = 12;

   // base mode register field positions
   localparam int BL_LSB = 0;
   localparam int BTYPE_BIT = 3;

   // encodings
   localparam logic [2:0] BL_FOUR = 3'h2;
   localparam logic [2:0] BL_EIGHT = 3'h3;
   localparam logic [2:0] ALAT_RESERVED = 3'h7;
   localparam logic [2:0] CAL_EXIT = 3'h0;
   localparam logic [2:0] CAL_DEFAULT = 3'h7;

   // termination codes {a6,a2}
   typedef enum logic [1:0] {TERM_OFF = 2'h0, TERM_75 = 2'h1, TERM_150 = 2'h2,
      TERM_50 = 2'h3} term_t;

   // timing: mode-register command cycle time and dll lock wait
   localparam int MRD_CYCLES = 2;
   localparam int DLL_LOCK_CYCLES = 200;

   // reset values of the device's copy (undefined on the part; extended copy zero, base fields 2 here)
   localparam logic [13:0] EXT_ONE_RESET = 14'h0000;
   localparam logic [3:0] BASE_RESET = 4'h2;

endpackage

// ### verilog/ddr2_cmd_if.sv
// command pins between memory controller and ddr2 device
// assumes both ends run on the same clock
`timescale 1ns/100ps
interface ddr2_cmd_if;
   logic cke;
   logic cs_n;
   logic ras_n;
   logic cas_n;
   logic we_n;
   logic [2:0] ba;
   logic [13:0] addr;
   logic self_refresh; // level: device in self refresh

   modport ctrl (output cke, cs_n, ras_n, cas_n, we_n, ba, addr, input self_refresh);
   modport dev (input cke, cs_n, ras_n, cas_n, we_n, ba, addr, output self_refresh);
endinterface

// ### verilog/ddr2_mode_dev.sv
// device end: decodes mode-register commands, holds extended_mode_one and
// the base burst fields, and generates the burst column order
// assumes commands synchronous to mclk_i
`timescale 1ns/100ps
module ddr2_mode_dev
   import ddr2_cfg_pkg::*;
(
   // clock and reset
   input wire logic mclk_i,
   input wire logic sys_rst_i,
   input wire logic clk_en_i,
   // command pins
   ddr2_cmd_if.dev link,
   // device state inputs
   input wire logic all_precharged_i,
   // burst request
   input wire logic burst_start_i,
   input wire logic [2:0] burst_col_i,
   // decoded configuration
   output logic dll_on_o,
   output logic drive_reduced_o,
   output logic outputs_on_o,
   output logic [2:0] add_lat_o,
   output logic alat_bad_o,
   output ddr2_cfg_pkg::term_t term_o,
   output logic cal_default_o,
   output logic cal_bad_o,
   output logic dm_mode_o,
   output logic rstrobe_oe_o,
   output logic rstrobe_n_oe_o,
   output logic strobe_n_oe_o,
   output logic self_refresh_o,
   // burst column
   output logic burst_valid_o,
   output logic [2:0] burst_col_o
);
   import ddr2_cfg_pkg::*;

   ////////////////////////////////////////////////////////////////////
   // command decode

   logic mrs_cmd; // all four strobes low, cke held high
   logic sr_entry; // refresh with cke falling
   logic sr_exit; // cke rising while in self refresh
   logic cke_q; // previous cke
   logic [13:0] ext_one_q; // extended_mode_one copy
   logic [3:0] base_q; // burst length and type from base register
   logic sr_q; // in self refresh

   assign mrs_cmd = cke_q && link.cke && !link.cs_n && !link.ras_n && !link.cas_n
      && !link.we_n;
   assign sr_entry = cke_q && !link.cke && !link.cs_n && !link.ras_n && !link.cas_n
      && link.we_n;
   assign sr_exit = sr_q && link.cke;

   // cke history for entry and mode command detection
   always_ff @(posedge mclk_i)
   begin
      if (sys_rst_i)
         cke_q <= 1'b0;
      else if (clk_en_i)
         cke_q <= link.cke;
   end

   // extended register load; ignored unless every bank is precharged
   always_ff @(posedge mclk_i)
   begin
      if (sys_rst_i)
         ext_one_q <= EXT_ONE_RESET;
      else if (clk_en_i && mrs_cmd && all_precharged_i && link.ba == BANK_EXT_ONE)
         ext_one_q <= link.addr;
   end

   // base register burst fields, same acceptance condition
   always_ff @(posedge mclk_i)
   begin
      if (sys_rst_i)
         base_q <= BASE_RESET;
      else if (clk_en_i && mrs_cmd && all_precharged_i && link.ba == 3'h0)
         base_q <= link.addr[3:0];
   end

   // self refresh state drives the automatic dll switch
   always_ff @(posedge mclk_i)
   begin
      if (sys_rst_i)
         sr_q <= 1'b0;
      else if (clk_en_i)
      begin
         if (sr_entry)
            sr_q <= 1'b1;
         else if (sr_exit)
            sr_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // field decode, registered so outputs come from flip-flops

   always_ff @(posedge mclk_i)
   begin
      if (sys_rst_i)
      begin
         dll_on_o <= 1'b0;
         drive_reduced_o <= 1'b0;
         outputs_on_o <= 1'b1;
         add_lat_o <= 3'h0;
         alat_bad_o <= 1'b0;
         term_o <= TERM_OFF;
         cal_default_o <= 1'b0;
         cal_bad_o <= 1'b0;
         dm_mode_o <= 1'b1;
         rstrobe_oe_o <= 1'b0;
         rstrobe_n_oe_o <= 1'b0;
         strobe_n_oe_o <= 1'b1;
         self_refresh_o <= 1'b0;
      end
      else if (clk_en_i)
      begin
         // dll runs only when enabled and not in self refresh
         dll_on_o <= !ext_one_q[DLL_OFF_BIT] && !sr_q;
         drive_reduced_o <= ext_one_q[DRIVE_HALF_BIT];
         outputs_on_o <= !ext_one_q[OUT_OFF_BIT];
         add_lat_o <= ext_one_q[ALAT_LSB +: 3];
         alat_bad_o <= ext_one_q[ALAT_LSB +: 3] == ALAT_RESERVED;
         term_o <= term_t'({ext_one_q[TERM_HI_BIT], ext_one_q[TERM_LO_BIT]});
         cal_default_o <= ext_one_q[CAL_LSB +: 3] == CAL_DEFAULT;
         cal_bad_o <= ext_one_q[CAL_LSB +: 3] != CAL_DEFAULT
            && ext_one_q[CAL_LSB +: 3] != CAL_EXIT;
         // shared pin is mask unless read strobe enabled
         dm_mode_o <= !ext_one_q[RSTROBE_ON_BIT];
         rstrobe_oe_o <= ext_one_q[RSTROBE_ON_BIT];
         rstrobe_n_oe_o <= ext_one_q[RSTROBE_ON_BIT] && !ext_one_q[NSTROBE_OFF_BIT];
         strobe_n_oe_o <= !ext_one_q[NSTROBE_OFF_BIT];
         self_refresh_o <= sr_q;
      end
   end

   assign link.self_refresh = sr_q;

   ////////////////////////////////////////////////////////////////////
   // burst column sequencer

   logic [2:0] start_q; // starting column
   logic [2:0] beat_q; // beat count
   logic active_q; // burst running
   logic [2:0] last_beat; // final beat for the length
   logic [2:0] col_next; // column for current beat

   assign last_beat = (base_q[BL_LSB +: 3] == BL_EIGHT) ? 3'h7 : 3'h3;

   // order generator; interleave xors, sequential wraps per nibble
   always_comb
   begin
      col_next = start_q ^ beat_q;
      if (!base_q[BTYPE_BIT])
      begin
         col_next[1:0] = start_q[1:0] + beat_q[1:0];
         col_next[2] = start_q[2] ^ beat_q[2];
      end
      if (last_beat == 3'h3)
         col_next[2] = start_q[2];
   end

   // beat counter
   always_ff @(posedge mclk_i)
   begin
      if (sys_rst_i)
      begin
         active_q <= 1'b0;
         beat_q <= 3'h0;
         start_q <= 3'h0;
      end
      else if (clk_en_i)
      begin
         if (burst_start_i)
         begin
            active_q <= 1'b1;
            beat_q <= 3'h0;
            start_q <= burst_col_i;
         end
         else if (active_q)
         begin
            beat_q <= beat_q + 3'h1;
            if (beat_q == last_beat)
               active_q <= 1'b0;
         end
      end
   end

   // registered column output
   always_ff @(posedge mclk_i)
   begin
      if (sys_rst_i)
      begin
         burst_valid_o <= 1'b0;
         burst_col_o <= 3'h0;
      end
      else if (clk_en_i)
      begin
         burst_valid_o <= active_q;
         burst_col_o <= col_next;
      end
   end

endmodule // ddr2_mode_dev

// ### sim/ddr2_link_assertions.sv
// checker for the command pins between controller and device
// assumes one clock; the bench instantiates it beside the interface
`timescale 1ns/100ps
module ddr2_link_assertions
   import ddr2_cfg_pkg::*;
#(
   parameter bit WIDE_PART = 1'b0
)
(
   // clock and reset
   input wire logic mclk_i,
   input wire logic sys_rst_i,
   // command pins
   input wire logic cke,
   input wire logic cs_n,
   input wire logic ras_n,
   input wire logic cas_n,
   input wire logic we_n,
   input wire logic [2:0] ba,
   input wire logic [13:0] addr,
   input wire logic self_refresh
);
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (sys_rst_i);
   ////////////////////////////////////////////////////////////////////////
   // mode command: all four strobes low
   wire logic mrs_w = !cs_n && !ras_n && !cas_n && !we_n;
   sequence mrs_cmd;
      mrs_w;
   endsequence
   // self refresh entry: refresh code with cke falling
   sequence sr_entry;
      $fell(cke) && !cs_n && !ras_n && !cas_n && we_n;
   endsequence
   ////////////////////////////////////////////////////////////////////////
   chk_mrs_bank: assert property (mrs_cmd |-> ba == BANK_EXT_ONE || ba == 3'h0)
      else $error("mode command on wrong bank");
   chk_top_bit: assert property (mrs_cmd |-> !addr[13])
      else $error("bit 13 set in mode command");
   chk_wide_rdqs: assert property (mrs_cmd |-> !(WIDE_PART && addr[11]))
      else $error("read strobe bit set on wide part");
   chk_mrs_cke: assert property (mrs_cmd |-> cke && $past(cke))
      else $error("mode command without cke high");
   // the command cycle time must pass before another mode command follows
   chk_mrs_gap: assert property (mrs_cmd |=> (!mrs_w) [*2])
      else $error("mode commands too close");
   chk_sr_entry: assert property (sr_entry |-> ##[1:2] self_refresh)
      else $error("self refresh not entered");
   chk_sr_exit: assert property ($rose(cke) && self_refresh |-> ##[1:2] !self_refresh)
      else $error("self refresh not left");
   chk_sr_no_mrs: assert property (self_refresh |-> !mrs_w)
      else $error("mode command during self refresh");
endmodule // ddr2_link_assertions

// ### sim/tb.sv
// testbench: apb orders into the controller, device outputs compared
// assumes the two ends joined by one interface on a 25 MHz clock
`timescale 1ns/100ps
module tb;
   import ddr2_cfg_pkg::*;
   logic mclk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic prech = 1'b1; // all banks precharged
   logic bstart = 1'b0;
   logic [2:0] bcol = 3'h0;
   logic dll_on, drv, outs_on, alb, cdef, cbad, dm, rs, rsn, sn, sr, bvalid;
   logic [2:0] al;
   logic [2:0] bcol_o;
   term_t term;
   int fails = 0;
   int checked = 0;
   int seed = 58930;
   logic [2:0] exp_q[$]; // expected burst columns, oldest first
   // all decoded settings except self refresh in one vector
   wire logic [14:0] cfg = {dll_on, drv, outs_on, al, alb, term, cdef, cbad, dm, rs, rsn, sn};
   ddr2_cmd_if lk();
   ddr2_mode_ctrl #(.MRD_WAIT(2), .LOCK_WAIT(4)) ddr2_mode_ctrl_i (.mclk_i(mclk_i),
      .sys_rst_i(sys_rst_i), .clk_en_i(1'b1), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
      .pready_o(pready), .pslverr_o(pslverr), .all_precharged_i(prech), .link(lk));
   ddr2_mode_dev ddr2_mode_dev_i (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .clk_en_i(1'b1),
      .link(lk), .all_precharged_i(prech), .burst_start_i(bstart), .burst_col_i(bcol),
      .dll_on_o(dll_on), .drive_reduced_o(drv), .outputs_on_o(outs_on), .add_lat_o(al),
      .alat_bad_o(alb), .term_o(term), .cal_default_o(cdef), .cal_bad_o(cbad),
      .dm_mode_o(dm), .rstrobe_oe_o(rs), .rstrobe_n_oe_o(rsn), .strobe_n_oe_o(sn),
      .self_refresh_o(sr), .burst_valid_o(bvalid), .burst_col_o(bcol_o));
   ddr2_link_assertions #(.WIDE_PART(1'b0)) ddr2_link_assertions_i (.mclk_i(mclk_i),
      .sys_rst_i(sys_rst_i), .cke(lk.cke), .cs_n(lk.cs_n), .ras_n(lk.ras_n),
      .cas_n(lk.cas_n), .we_n(lk.we_n), .ba(lk.ba), .addr(lk.addr),
      .self_refresh(lk.self_refresh));
   ////////////////////////////////////////////////////////////////////////
   initial forever #20 mclk_i = ~mclk_i;
   // compare and count
   task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         fails++;
         $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic print_verdict();
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // expected decode of the extended register
   function automatic logic [14:0] decode(logic [13:0] v);
      return {!v[0], v[1], !v[12], v[5:3], v[5:3] == 3'h7, v[6], v[2], v[9:7] == 3'h7,
         !(v[9:7] == 3'h0 || v[9:7] == 3'h7), !v[11], v[11], v[11] && !v[10], !v[10]};
   endfunction
   // expected column: offset wraps in the nibble, nibble swaps after four beats
   function automatic logic [2:0] ord(logic [2:0] s, logic [2:0] k, logic il);
      return il ? (s ^ k) : {k[2] ? !s[2] : s[2], 2'((s + k) % 4)};
   endfunction
   // one apb transfer; entered just after a rising edge, holds until pready
   task automatic apb(logic wr, logic [11:0] a, logic [31:0] wd, output logic [31:0] rd,
      output logic err);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge mclk_i);
      penable <= 1'b1;
      do @(posedge mclk_i); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk_i);
   endtask
   // poll status until write done and not busy
   task automatic wait_done();
      logic [31:0] r;
      logic e;
      do apb(1'b0, 12'h008, 32'h0, r, e); while (r[1:0] !== 2'b10);
   endtask
   task automatic wait_sr(logic lvl);
      while (sr !== lvl) @(posedge mclk_i);
   endtask
   ////////////////////////////////////////////////////////////////////////
   // burst monitor: each beat takes the oldest note
   always @(posedge mclk_i)
   begin
      if (bvalid === 1'b1)
         check("burst_col", bcol_o, exp_q.size() ? exp_q.pop_front() : 3'hX);
   end
   initial
   begin
      #800000;
      fails++;
      print_verdict();
   end
   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      logic [31:0] r;
      logic e;
      logic [13:0] v;
      logic [2:0] hi;
      int bl;
      logic bt;
      repeat (10) @(posedge mclk_i);
      // reset values still stand at this edge, so no race with their launch
      check("reset_cfg", cfg, 15'h1009);
      sys_rst_i <= 1'b0;
      @(posedge mclk_i);
      apb(1'b0, 12'h0FC, 32'h0, r, e);
      check("unmapped_err", e, 1'b1);
      check("unmapped_data", r, 32'h0);
      // every latency, calibration and termination code, random other bits
      for (int i = 0; i < 8; i++)
      begin
         v = 14'($random(seed));
         v[5:3] = 3'(i);
         v[9:7] = 3'(i);
         {v[6], v[2]} = 2'(i);
         apb(1'b1, 12'h000, {18'h0, v}, r, e);
         apb(1'b1, 12'h004, 32'h1, r, e);
         wait_done();
         check("ext_cfg", cfg, decode(v));
         apb(1'b0, 12'h000, 32'h0, r, e);
         check("ext_readback", r[13:0], {1'b0, v[12:0]});
         apb(1'b0, 12'h008, 32'h0, r, e);
         check("lock_done", r[2], !v[0]);
      end
      // a rewrite waits while a bank is open
      prech <= 1'b0;
      apb(1'b1, 12'h000, 32'h1002, r, e);
      apb(1'b1, 12'h004, 32'h1, r, e);
      repeat (6) @(posedge mclk_i);
      check("held_cfg", cfg, decode(v));
      prech <= 1'b1;
      wait_done();
      check("rewrite_cfg", cfg, decode(14'h1002));
      // self refresh drops the dll and restores it on exit
      apb(1'b1, 12'h004, 32'h2, r, e);
      wait_sr(1'b1);
      check("sr_dll", dll_on, 1'b0);
      apb(1'b0, 12'h008, 32'h0, r, e);
      check("sr_status", r[3:2], 2'b10);
      apb(1'b1, 12'h004, 32'h0, r, e);
      wait_sr(1'b0);
      repeat (2) @(posedge mclk_i);
      check("sr_exit_dll", dll_on, 1'b1);
      apb(1'b0, 12'h008, 32'h0, r, e);
      check("sr_exit_lock", r[3:2], 2'b01);
      // back to back bursts of four, sequential, every start offset within a random nibble
      for (int s = 0; s < 4; s++)
      begin
         hi = 3'($random(seed));
         bstart <= 1'b1;
         bcol <= {hi[2], 2'(s)};
         for (int k = 0; k < 4; k++)
            exp_q.push_back({hi[2], 2'(s + k)});
         @(posedge mclk_i);
         bstart <= 1'b0;
         repeat (3) @(posedge mclk_i);
      end
      // base register loads: eight sequential, eight interleaved, four interleaved
      for (int m = 0; m < 3; m++)
      begin
         bl = (m < 2) ? 8 : 4;
         bt = (m > 0);
         apb(1'b1, 12'h00C, {28'h0, bt, (m < 2) ? BL_EIGHT : BL_FOUR}, r, e);
         apb(1'b1, 12'h004, 32'h5, r, e);
         wait_done();
         for (int s = 0; s < 8; s++)
         begin
            bstart <= 1'b1;
            bcol <= 3'(s);
            for (int k = 0; k < bl; k++)
               exp_q.push_back(ord(3'(s), 3'(k), bt));
            @(posedge mclk_i);
            bstart <= 1'b0;
            repeat (bl - 1) @(posedge mclk_i);
         end
      end
      repeat (8) @(posedge mclk_i);
      check("burst_left", exp_q.size(), 0);
      print_verdict();
   end
endmodule // tb
